//--- rtl/lcd_port_pkg.sv
// Purpose: Shared constants for the display host port and its host end.
// Assumes: One 250 MHz clock; bus pins sampled synchronously.
// Notes: Register offsets, reset values and pixel layouts live here.
package lcd_port_pkg;
    localparam int BUS_W = 18;
    localparam logic [7:0] OFF_XS_HI = 8'h00;
    localparam logic [7:0] OFF_XS_LO = 8'h01;
    localparam logic [7:0] OFF_XE_HI = 8'h02;
    localparam logic [7:0] OFF_XE_LO = 8'h03;
    localparam logic [7:0] OFF_YS_HI = 8'h04;
    localparam logic [7:0] OFF_YS_LO = 8'h05;
    localparam logic [7:0] OFF_YE_HI = 8'h06;
    localparam logic [7:0] OFF_YE_LO = 8'h07;
    localparam logic [7:0] OFF_PW_HI = 8'h08;
    localparam logic [7:0] OFF_PW_LO = 8'h09;
    localparam logic [7:0] OFF_WA_TOP = 8'h0a;
    localparam logic [7:0] OFF_WA_MID = 8'h0b;
    localparam logic [7:0] OFF_WA_LOW = 8'h0c;
    localparam logic [7:0] OFF_OUT_CFG = 8'h10;
    localparam logic [7:0] OFF_TEST_R = 8'h2a;
    localparam logic [7:0] OFF_TEST_G = 8'h2b;
    localparam logic [7:0] OFF_TEST_B = 8'h2c;
    localparam logic [7:0] RST_XS_HI = 8'h00;
    localparam logic [7:0] RST_XS_LO = 8'h00;
    localparam logic [7:0] RST_XE_HI = 8'h01;
    localparam logic [7:0] RST_XE_LO = 8'h3f;
    localparam logic [7:0] RST_YS_HI = 8'h00;
    localparam logic [7:0] RST_YS_LO = 8'h00;
    localparam logic [7:0] RST_YE_HI = 8'h00;
    localparam logic [7:0] RST_YE_LO = 8'hef;
    localparam logic [7:0] RST_PW_HI = 8'h01;
    localparam logic [7:0] RST_PW_LO = 8'h40;
    localparam logic [7:0] RST_WA = 8'h00;
    localparam logic [7:0] RST_OUT_CFG = 8'h0d;
    localparam logic [6:0] RST_TEST = 7'h00;
    // Output configuration field positions.
    localparam int CFG_CLK_LSB = 0;
    localparam int CFG_PAR_BIT = 2;
    localparam int CFG_BLANK_BIT = 3;
    localparam int CFG_TEST_BIT = 6;
    // Dot clock divide ratios from the 40 MHz reference, per clock-select code.
    localparam int PLL_MHZ = 40;
    localparam int DOT_MHZ_00 = 20;
    localparam int DOT_MHZ_01 = 10;
    localparam int DOT_MHZ_10 = 5;
    localparam int CLK_MHZ = 250;
    localparam int PLL_DIV = CLK_MHZ / PLL_MHZ;
    // Bus width selections.
    typedef enum logic [1:0] {
        BUS_8 = 2'b00,
        BUS_9 = 2'b01,
        BUS_16 = 2'b10,
        BUS_18 = 2'b11
    } bus_width_e;
    // Assemble a pixel as 18-bit RGB666 from up to three captured words.
    function automatic logic [17:0] pack_pixel(input bus_width_e bw, input logic deep,
                                               input logic [17:0] w0, input logic [17:0] w1,
                                               input logic [17:0] w2);
        logic [17:0] p;
        p = 18'h0;
        unique case (bw)
            BUS_18: p = w0;
            BUS_16: p = deep ? {w0[1:0], w1[15:0]} : {w0[15:11], 1'b0, w0[10:5], w0[4:0], 1'b0};
            BUS_9: p = {w0[8:0], w1[8:0]};
            BUS_8: p = deep ? {w0[1:0], w1[7:0], w2[7:0]} : {w0[7:3], 1'b0, w0[2:0], w1[7:5], w1[4:0], 1'b0};
        endcase
        return p;
    endfunction
    // Number of bus words that make one pixel.
    function automatic logic [1:0] words_per_pixel(input bus_width_e bw, input logic deep);
        logic [1:0] n;
        n = 2'd1;
        unique case (bw)
            BUS_18: n = 2'd1;
            BUS_16: n = deep ? 2'd2 : 2'd1;
            BUS_9: n = 2'd2;
            BUS_8: n = deep ? 2'd3 : 2'd2;
        endcase
        return n;
    endfunction
endpackage

//--- rtl/lcd_host_if.sv
// Purpose: Parallel host bus between a microcontroller and the display port.
// Assumes: Data bus is resolved from the two output enables (low = driving).
// Notes: No clocking block; both ends sample on the shared clock.
`timescale 1ns/1ps
`default_nettype none
interface lcd_host_if;
    logic reset_pin_n;
    logic cs_n;
    logic rs;
    logic wr_e;
    logic rd_rw;
    logic colour_depth_sel;
    logic [17:0] host_data_out;
    logic host_data_oe_n;
    logic [17:0] dev_data_out;
    logic dev_data_oe_n;
    logic [17:0] host_data_bus;
    assign host_data_bus = !host_data_oe_n ? host_data_out : (!dev_data_oe_n ? dev_data_out : 18'h0);
    modport host (output reset_pin_n, cs_n, rs, wr_e, rd_rw, colour_depth_sel, host_data_out,
                  host_data_oe_n, input host_data_bus);
    modport device (input reset_pin_n, cs_n, rs, wr_e, rd_rw, colour_depth_sel, host_data_bus,
                    output dev_data_out, dev_data_oe_n);
endinterface
`default_nettype wire

//--- rtl/lcd_device_port.sv
// Purpose: Display controller end of the parallel host port.
// Assumes: Host pins are synchronous to clk; strobes last at least two cycles.
// Notes: Register reads return the register at the last written index.
// Operation
// - Transfers only while chip select is low
// - Select line routes register versus data
// - 8080 write uses low write strobe
// - 8080 read strobe; device drives bus
// - 6800 mode latches on E rising
// - 6800 R/W high reads, low writes
// - Colour pin picks 262K or 65K
// - 18-bit 262K: one word per pixel
// - 16-bit 65K: one word RGB565
// - 16-bit 262K: two words per pixel
// - 9-bit 262K: two words per pixel
// - 8-bit 65K: two words per pixel
// - 8-bit 262K: three words per pixel
// - RAM writes confined to window
// - Address counter advances after each write
// - Panel width register is row pitch
// - Clock select divides 40 MHz dot clock
// - Bit 2 selects serial or parallel
// - Bit 3 blanks output when zero
// - Bit 6 drives test pattern outputs
// - Active-low reset pin restores defaults
`timescale 1ns/1ps
`default_nettype none
module lcd_device_port #(
    parameter lcd_port_pkg::bus_width_e BUS_WIDTH = lcd_port_pkg::BUS_18,
    parameter bit MODE_6800 = 1'b0,
    parameter int ADDR_W = 18
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    // Host pins.
    lcd_host_if.device bus,
    // Display RAM write port.
    output logic ram_we,
    output logic [ADDR_W-1:0] ram_addr,
    output logic [17:0] ram_data,
    // Panel side.
    output logic dot_clk_en,
    output logic panel_parallel,
    output logic [17:0] panel_rgb,
    output logic [20:0] test_rgb,
    output logic test_mode,
    output logic blank_n
);
    import lcd_port_pkg::*;
    logic [7:0] xs_hi, xs_lo, xe_hi, xe_lo, ys_hi, ys_lo, ye_hi, ye_lo;
    logic [7:0] pw_hi, pw_lo, wa_top, wa_mid, wa_low, out_cfg;
    logic [6:0] test_r, test_g, test_b;
    logic [7:0] index;
    logic wr_q, regs_rst_n;
    logic active, write_take, read_cycle;
    logic [17:0] w0, w1;
    logic [1:0] word_cnt;
    logic [15:0] cur_x, cur_y;
    logic [15:0] next_x, next_y;
    logic [7:0] rd_val;
    logic [7:0] pll_cnt;
    logic [3:0] dot_cnt;
    logic pixel_done;
    logic soft_rst;
    assign soft_rst = !bus.reset_pin_n;
    assign active = !bus.cs_n;
    // 8080: write strobe rising edge; 6800: E rising edge with R/W low.
    assign write_take = active && wr_q == (MODE_6800 ? 1'b0 : 1'b0) && bus.wr_e
                        && (MODE_6800 ? !bus.rd_rw : 1'b1);
    assign read_cycle = active && (MODE_6800 ? (bus.wr_e && bus.rd_rw) : !bus.rd_rw);
    assign pixel_done = write_take && bus.rs && (word_cnt + 2'd1 == words_per_pixel(BUS_WIDTH, bus.colour_depth_sel));
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_q <= 1'b1;
            regs_rst_n <= 1'b0;
        end else begin
            wr_q <= bus.wr_e;
            regs_rst_n <= !soft_rst;
        end
    end
    // Register file; index write when select is low, register write when high.
    always_ff @(posedge clk or negedge regs_rst_n) begin
        if (!regs_rst_n) begin
            index <= 8'h00;
            xs_hi <= RST_XS_HI;
            xs_lo <= RST_XS_LO;
            xe_hi <= RST_XE_HI;
            xe_lo <= RST_XE_LO;
            ys_hi <= RST_YS_HI;
            ys_lo <= RST_YS_LO;
            ye_hi <= RST_YE_HI;
            ye_lo <= RST_YE_LO;
            pw_hi <= RST_PW_HI;
            pw_lo <= RST_PW_LO;
            wa_top <= RST_WA;
            wa_mid <= RST_WA;
            wa_low <= RST_WA;
            out_cfg <= RST_OUT_CFG;
            test_r <= RST_TEST;
            test_g <= RST_TEST;
            test_b <= RST_TEST;
        end else if (write_take && !bus.rs) begin
            index <= bus.host_data_bus[7:0];
        end else if (write_take && index != 8'hff && bus.rs && index != 8'hfe) begin
            unique case (index)
                OFF_XS_HI: xs_hi <= bus.host_data_bus[7:0];
                OFF_XS_LO: xs_lo <= bus.host_data_bus[7:0];
                OFF_XE_HI: xe_hi <= bus.host_data_bus[7:0];
                OFF_XE_LO: xe_lo <= bus.host_data_bus[7:0];
                OFF_YS_HI: ys_hi <= bus.host_data_bus[7:0];
                OFF_YS_LO: ys_lo <= bus.host_data_bus[7:0];
                OFF_YE_HI: ye_hi <= bus.host_data_bus[7:0];
                OFF_YE_LO: ye_lo <= bus.host_data_bus[7:0];
                OFF_PW_HI: pw_hi <= bus.host_data_bus[7:0];
                OFF_PW_LO: pw_lo <= bus.host_data_bus[7:0];
                OFF_WA_TOP: wa_top <= bus.host_data_bus[7:0];
                OFF_WA_MID: wa_mid <= bus.host_data_bus[7:0];
                OFF_WA_LOW: wa_low <= bus.host_data_bus[7:0];
                OFF_OUT_CFG: out_cfg <= bus.host_data_bus[7:0];
                OFF_TEST_R: test_r <= bus.host_data_bus[6:0];
                OFF_TEST_G: test_g <= bus.host_data_bus[6:0];
                OFF_TEST_B: test_b <= bus.host_data_bus[6:0];
                default: ;
            endcase
        end
    end
    // Read-back of the selected register.
    always_comb begin
        unique case (index)
            OFF_XS_HI: rd_val = xs_hi;
            OFF_XS_LO: rd_val = xs_lo;
            OFF_XE_HI: rd_val = xe_hi;
            OFF_XE_LO: rd_val = xe_lo;
            OFF_YS_HI: rd_val = ys_hi;
            OFF_YS_LO: rd_val = ys_lo;
            OFF_YE_HI: rd_val = ye_hi;
            OFF_YE_LO: rd_val = ye_lo;
            OFF_PW_HI: rd_val = pw_hi;
            OFF_PW_LO: rd_val = pw_lo;
            OFF_WA_TOP: rd_val = wa_top;
            OFF_WA_MID: rd_val = wa_mid;
            OFF_WA_LOW: rd_val = wa_low;
            OFF_OUT_CFG: rd_val = out_cfg;
            OFF_TEST_R: rd_val = {1'b0, test_r};
            OFF_TEST_G: rd_val = {1'b0, test_g};
            OFF_TEST_B: rd_val = {1'b0, test_b};
            default: rd_val = 8'h00;
        endcase
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bus.dev_data_oe_n <= 1'b1;
            bus.dev_data_out <= 18'h0;
        end else begin
            bus.dev_data_oe_n <= !read_cycle;
            bus.dev_data_out <= {10'h0, rd_val};
        end
    end
    // Pixel word gathering.
    always_ff @(posedge clk or negedge regs_rst_n) begin
        if (!regs_rst_n) begin
            word_cnt <= 2'd0;
            w0 <= 18'h0;
            w1 <= 18'h0;
        end else if (write_take && !bus.rs) begin
            word_cnt <= 2'd0;
        end else if (write_take && bus.rs && index == 8'hff) begin
            word_cnt <= 2'd0;
        end else if (write_take && bus.rs && index > OFF_TEST_B) begin
            if (pixel_done) begin
                word_cnt <= 2'd0;
            end else begin
                word_cnt <= word_cnt + 2'd1;
            end
            if (word_cnt == 2'd0) begin
                w0 <= bus.host_data_bus;
            end else begin
                w1 <= bus.host_data_bus;
            end
        end
    end
    // Window address counter and RAM write.
    always_comb begin
        next_x = cur_x + 16'd1;
        next_y = cur_y;
        if (cur_x >= {xe_hi, xe_lo}) begin
            next_x = {xs_hi, xs_lo};
            next_y = (cur_y >= {ye_hi, ye_lo}) ? {ys_hi, ys_lo} : cur_y + 16'd1;
        end
    end
    always_ff @(posedge clk or negedge regs_rst_n) begin
        if (!regs_rst_n) begin
            cur_x <= 16'h0;
            cur_y <= 16'h0;
            ram_we <= 1'b0;
            ram_addr <= '0;
            ram_data <= 18'h0;
        end else begin
            ram_we <= 1'b0;
            if (write_take && !bus.rs) begin
                cur_x <= {xs_hi, xs_lo};
                cur_y <= {ys_hi, ys_lo};
            end else if (pixel_done && index > OFF_TEST_B) begin
                ram_we <= 1'b1;
                ram_addr <= ADDR_W'({wa_top[1:0], wa_mid, wa_low} + cur_y * {pw_hi[1:0], pw_lo} + cur_x);
                ram_data <= pack_pixel(BUS_WIDTH, bus.colour_depth_sel, word_cnt == 2'd0 ? bus.host_data_bus : w0,
                                       word_cnt == 2'd2 ? w1 : bus.host_data_bus,
                                       bus.host_data_bus);
                cur_x <= next_x;
                cur_y <= next_y;
            end
        end
    end
    // Dot clock enable from the 40 MHz reference.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pll_cnt <= 8'h0;
            dot_cnt <= 4'h0;
            dot_clk_en <= 1'b0;
        end else begin
            dot_clk_en <= 1'b0;
            pll_cnt <= (pll_cnt == 8'(PLL_DIV - 1)) ? 8'h0 : pll_cnt + 8'h1;
            if (pll_cnt == 8'(PLL_DIV - 1)) begin
                if (dot_cnt >= (out_cfg[CFG_CLK_LSB +: 2] == 2'b00 ? 4'(PLL_MHZ / DOT_MHZ_00 - 1) :
                                out_cfg[CFG_CLK_LSB +: 2] == 2'b01 ? 4'(PLL_MHZ / DOT_MHZ_01 - 1) :
                                4'(PLL_MHZ / DOT_MHZ_10 - 1))) begin
                    dot_cnt <= 4'h0;
                    dot_clk_en <= 1'b1;
                end else begin
                    dot_cnt <= dot_cnt + 4'h1;
                end
            end
        end
    end
    // Panel outputs.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            panel_parallel <= 1'b0;
            blank_n <= 1'b0;
            test_mode <= 1'b0;
            test_rgb <= 21'h0;
            panel_rgb <= 18'h0;
        end else begin
            panel_parallel <= out_cfg[CFG_PAR_BIT];
            blank_n <= out_cfg[CFG_BLANK_BIT];
            test_mode <= out_cfg[CFG_TEST_BIT];
            test_rgb <= {test_r, test_g, test_b};
            if (!out_cfg[CFG_BLANK_BIT]) begin
                panel_rgb <= 18'h0;
            end else if (out_cfg[CFG_TEST_BIT]) begin
                panel_rgb <= {test_r[5:0], test_g[5:0], test_b[5:0]};
            end else begin
                panel_rgb <= ram_data;
            end
        end
    end
endmodule
`default_nettype wire

//--- rtl/lcd_host_master.sv
// Purpose: Microcontroller end that runs register and pixel cycles on the port.
// Assumes: One request at a time; strobe phases last STROBE_CYC cycles.
// Notes: A pixel request is split into bus words per width and colour depth.
`timescale 1ns/1ps
`default_nettype none
module lcd_host_master #(
    parameter lcd_port_pkg::bus_width_e BUS_WIDTH = lcd_port_pkg::BUS_18,
    parameter bit MODE_6800 = 1'b0,
    parameter int STROBE_CYC = 25
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    // User request.
    input wire logic req_valid,
    input wire logic [1:0] req_kind,
    input wire logic [17:0] req_data,
    input wire logic deep_colour,
    input wire logic panel_reset,
    output logic req_ready,
    output logic rd_valid,
    output logic [7:0] rd_data,
    // Pins.
    lcd_host_if.host bus
);
    import lcd_port_pkg::*;
    typedef enum logic [1:0] {
        IDLE = 2'b00,
        SETUP = 2'b01,
        STROBE = 2'b10,
        HOLD = 2'b11
    } phase_e;
    phase_e phase;
    logic [7:0] cnt;
    logic [1:0] word, words;
    logic [17:0] pix;
    logic is_read, is_data, is_pixel;
    function automatic logic [17:0] word_of(input logic [17:0] p, input logic [1:0] i, input logic d);
        logic [17:0] w;
        w = p;
        unique case (BUS_WIDTH)
            BUS_18: w = p;
            BUS_16: w = d ? (i == 2'd0 ? {16'h0, p[17:16]} : {2'b0, p[15:0]}) :
                            {2'b0, p[17:13], p[11:6], p[5:1]};
            BUS_9: w = i == 2'd0 ? {9'h0, p[17:9]} : {9'h0, p[8:0]};
            BUS_8: w = d ? (i == 2'd0 ? {16'h0, p[17:16]} : i == 2'd1 ? {10'h0, p[15:8]} : {10'h0, p[7:0]}) :
                           (i == 2'd0 ? {10'h0, p[17:13], p[11:9]} : {10'h0, p[8:6], p[5:1]});
        endcase
        return w;
    endfunction
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase <= IDLE;
            cnt <= 8'h0;
            word <= 2'd0;
            words <= 2'd1;
            pix <= 18'h0;
            is_read <= 1'b0;
            is_data <= 1'b0;
            is_pixel <= 1'b0;
            req_ready <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= 8'h0;
            bus.reset_pin_n <= 1'b0;
            bus.cs_n <= 1'b1;
            bus.rs <= 1'b0;
            bus.wr_e <= MODE_6800 ? 1'b0 : 1'b1;
            bus.rd_rw <= 1'b1;
            bus.colour_depth_sel <= 1'b0;
            bus.host_data_out <= 18'h0;
            bus.host_data_oe_n <= 1'b1;
        end else begin
            rd_valid <= 1'b0;
            bus.reset_pin_n <= !panel_reset;
            bus.colour_depth_sel <= deep_colour;
            unique case (phase)
                IDLE: begin
                    req_ready <= 1'b1;
                    if (req_valid && req_ready) begin
                        req_ready <= 1'b0;
                        is_read <= req_kind == 2'd2;
                        is_data <= req_kind == 2'd1 || req_kind == 2'd3;
                        is_pixel <= req_kind == 2'd3;
                        pix <= req_data;
                        word <= 2'd0;
                        words <= req_kind == 2'd3 ? words_per_pixel(BUS_WIDTH, deep_colour) : 2'd1;
                        phase <= SETUP;
                        cnt <= 8'h0;
                    end
                end
                SETUP: begin
                    bus.cs_n <= 1'b0;
                    bus.rs <= is_data || is_read;
                    if (MODE_6800) begin
                        bus.rd_rw <= is_read;
                    end
                    bus.host_data_oe_n <= is_read;
                    bus.host_data_out <= is_pixel ?
                                         word_of(pix, word, deep_colour) : pix;
                    phase <= STROBE;
                    cnt <= 8'h0;
                end
                STROBE: begin
                    cnt <= cnt + 8'h1;
                    if (MODE_6800) begin
                        bus.wr_e <= 1'b1;
                    end else if (is_read) begin
                        bus.rd_rw <= 1'b0;
                    end else begin
                        bus.wr_e <= 1'b0;
                    end
                    if (cnt == 8'(STROBE_CYC)) begin
                        bus.wr_e <= MODE_6800 ? 1'b0 : 1'b1;
                        bus.rd_rw <= 1'b1;
                        if (is_read) begin
                            rd_valid <= 1'b1;
                            rd_data <= bus.host_data_bus[7:0];
                        end
                        phase <= HOLD;
                        cnt <= 8'h0;
                    end
                end
                HOLD: begin
                    cnt <= cnt + 8'h1;
                    if (cnt == 8'(STROBE_CYC - 1)) begin
                        if (word + 2'd1 < words) begin
                            word <= word + 2'd1;
                            phase <= SETUP;
                        end else begin
                            bus.cs_n <= 1'b1;
                            bus.host_data_oe_n <= 1'b1;
                            phase <= IDLE;
                        end
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

//--- test/lcd_host_port_asserts.sv
// Purpose: Concurrent checks on the host port wires between the two ends.
// Assumes: 8080 mode, one clock.
// Notes: Instantiated beside the interface in the bench.
`timescale 1ns/1ps
`default_nettype none
module lcd_host_port_asserts (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    // Host port wires.
    input wire logic cs_n,
    input wire logic rs,
    input wire logic wr_e,
    input wire logic rd_rw,
    input wire logic [17:0] host_data_out,
    input wire logic host_data_oe_n,
    input wire logic dev_data_oe_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_dev_needs_select: assert property (!dev_data_oe_n |-> !$past(cs_n))
        else $error("device drove unselected");
    a_dev_needs_read: assert property (!dev_data_oe_n |-> !$past(rd_rw))
        else $error("device drove outside read");
    a_no_contention: assert property (!(!dev_data_oe_n && !host_data_oe_n))
        else $error("both ends drive the bus");
    a_read_answer: assert property (!cs_n && $fell(rd_rw) |-> ##[1:2] !dev_data_oe_n)
        else $error("no read answer");
    a_read_release: assert property ($rose(rd_rw) |-> ##[0:1] dev_data_oe_n)
        else $error("bus not released");
    a_write_select: assert property ($fell(wr_e) |-> !cs_n)
        else $error("write strobe without select");
    a_write_width: assert property ($fell(wr_e) |=> !wr_e ##1 !host_data_oe_n)
        else $error("write strobe too short");
    a_write_hold: assert property (!wr_e && !$past(wr_e) |-> $stable(rs) && $stable(host_data_out))
        else $error("select or data moved in strobe");
endmodule
`default_nettype wire

//--- test/lcd_host_port_window_regs_bench.sv
// Purpose: Self-checking bench for the host end and display end joined.
// Assumes: 8-bit 8080 bus with short strobes.
// Notes: Pixels go to index 0x40 inside a 2x2 window.
`timescale 1ns/1ps
`default_nettype none
module lcd_host_port_window_regs_bench;
    import lcd_port_pkg::*;
    logic clk, reset_n, req_valid, deep_colour, panel_reset, req_ready, rd_valid, ram_we;
    logic dot_clk_en, panel_parallel, test_mode, blank_n;
    logic [1:0] req_kind;
    logic [7:0] rd_data, last_rd;
    logic [17:0] req_data, ram_addr, ram_data, panel_rgb, last_addr, last_px;
    logic [20:0] test_rgb;
    int error_cnt, compares, we_cnt;
    lcd_host_if bus_if();
    lcd_host_master #(.BUS_WIDTH(BUS_8), .STROBE_CYC(2)) u_lcd_host_master (.clk(clk), .reset_n(reset_n),
        .req_valid(req_valid), .req_kind(req_kind), .req_data(req_data), .deep_colour(deep_colour),
        .panel_reset(panel_reset), .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .bus(bus_if));
    lcd_device_port #(.BUS_WIDTH(BUS_8)) u_lcd_device_port (.clk(clk), .reset_n(reset_n), .bus(bus_if),
        .ram_we(ram_we), .ram_addr(ram_addr), .ram_data(ram_data), .dot_clk_en(dot_clk_en),
        .panel_parallel(panel_parallel), .panel_rgb(panel_rgb), .test_rgb(test_rgb), .test_mode(test_mode),
        .blank_n(blank_n));
    lcd_host_port_asserts u_lcd_host_port_asserts (.clk(clk), .reset_n(reset_n), .cs_n(bus_if.cs_n),
        .rs(bus_if.rs), .wr_e(bus_if.wr_e), .rd_rw(bus_if.rd_rw), .host_data_out(bus_if.host_data_out),
        .host_data_oe_n(bus_if.host_data_oe_n), .dev_data_oe_n(bus_if.dev_data_oe_n));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rd_valid === 1'b1) last_rd <= rd_data;
        if (ram_we === 1'b1) begin
            last_addr <= ram_addr;
            last_px <= ram_data;
            we_cnt <= we_cnt + 1;
        end
    end
    task automatic check(input string what, input logic [20:0] seen, input logic [20:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic send(input logic [1:0] kind, input logic [17:0] data);
        @(negedge clk);
        req_valid = 1'b1;
        req_kind = kind;
        req_data = data;
        do @(posedge clk); while (req_ready !== 1'b1);
        @(negedge clk);
        req_valid = 1'b0;
        while (req_ready !== 1'b1) @(negedge clk);
        repeat (3) @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] val);
        send(2'd0, {10'h0, idx});
        send(2'd1, {10'h0, val});
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        send(2'd0, {10'h0, idx});
        send(2'd2, 18'h0);
        check("register", {13'h0, last_rd}, {13'h0, exp});
    endtask
    task automatic t_defaults();
        rd_chk(OFF_XE_LO, RST_XE_LO);
        rd_chk(OFF_PW_LO, RST_PW_LO);
        rd_chk(OFF_OUT_CFG, RST_OUT_CFG);
        rd_chk(8'h0f, 8'h00);
        check("parallel", panel_parallel, 1);
        check("blank", blank_n, 1);
    endtask
    task automatic count_dots(output int n);
        n = 0;
        repeat (240) begin
            @(posedge clk);
            #1 if (dot_clk_en === 1'b1) n++;
        end
    endtask
    task automatic t_config();
        int n;
        wr(OFF_TEST_R, 8'h3f);
        wr(OFF_OUT_CFG, 8'h41);
        check("test", {test_mode, test_rgb[20:14]}, 8'hbf);
        check("blank_par", {blank_n, panel_parallel}, 0);
        count_dots(n);
        check("dot", n, 240 / (PLL_DIV * 4));
        wr(OFF_OUT_CFG, 8'h4e);
        check("test_pixel", panel_rgb, 18'h3f000);
        check("blank_par_on", {blank_n, panel_parallel}, 3);
        count_dots(n);
        check("dot_slow", n, 240 / (PLL_DIV * 8));
        @(negedge clk);
        panel_reset = 1'b1;
        repeat (4) @(negedge clk);
        panel_reset = 1'b0;
        repeat (4) @(negedge clk);
        rd_chk(OFF_OUT_CFG, RST_OUT_CFG);
    endtask
    task automatic t_pixels();
        logic [17:0] p;
        wr(OFF_XE_HI, 8'h00);
        wr(OFF_XE_LO, 8'h01);
        wr(OFF_YE_LO, 8'h01);
        send(2'd0, 18'h40);
        for (int i = 0; i < 5; i++) begin
            p = 18'h2a5c3 + 18'(i);
            send(2'd3, p);
            check("addr", last_addr, 21'(((i / 2) % 2) * 320 + i % 2));
            check("pixel", last_px, {p[17:13], 1'b0, p[11:6], p[5:1], 1'b0});
        end
        check("writes", we_cnt, 5);
        deep_colour = 1'b1;
        send(2'd0, 18'h40);
        send(2'd3, 18'h2d5a6);
        check("deep", {last_addr[2:0], last_px}, 21'h2d5a6);
    endtask
    task automatic summarize();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        {reset_n, req_valid, deep_colour, panel_reset, req_kind, req_data} = '0;
        {error_cnt, compares, we_cnt} = '0;
        repeat (6) @(negedge clk);
        reset_n = 1'b1;
        t_defaults();
        t_config();
        t_pixels();
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        summarize();
    end
endmodule
`default_nettype wire
